/* File: include/seerd_pkg.sv */
// shared constants and types for the serial eeprom read path
package seerd_pkg;

	localparam int CLK_PERIOD_NS = 5;
	// internal programming time after a stop that ends a write
	localparam int T_WR_NS = 10_000_000;
	localparam int WR_CYCLES = T_WR_NS / CLK_PERIOD_NS;
	localparam int BUSY_W = 22;
	// serial clock period made by the bus master end
	localparam int T_SCL_NS = 2500;
	localparam int SCL_QTR_CYCLES = T_SCL_NS / 4 / CLK_PERIOD_NS;
	localparam int DIV_W = 7;

	localparam int MEM_AW = 10;
	localparam int MEM_DEPTH = 1024;
	localparam int PAGE_BITS = 4;

	// control byte layout
	localparam logic [3:0] DEV_TYPE = 4'ha;
	localparam int CTRL_RW_POS = 0;
	localparam int CTRL_BLK_LSB = 1;
	localparam int CTRL_TYPE_LSB = 4;

	// bit counter values inside one nine-clock byte slot
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_END = 4'h9;

	// master sequencer steps
	localparam logic [2:0] STEP_START = 3'h0;
	localparam logic [2:0] STEP_CTRL_W = 3'h1;
	localparam logic [2:0] STEP_ADDR = 3'h2;
	localparam logic [2:0] STEP_RESTART = 3'h3;
	localparam logic [2:0] STEP_CTRL_R = 3'h4;
	localparam logic [2:0] STEP_RX = 3'h5;
	localparam logic [2:0] STEP_STOP = 3'h6;
	localparam logic [2:0] STEP_WDATA = 3'h7;

	typedef enum logic [1:0] {
		seerd_cur_read,
		seerd_rand_read,
		seerd_write
	} seerd_kind_e;

endpackage

/* File: include/seerd_if.sv */
// two-wire link between the bus master end and the memory end
`timescale 1ns/100ps
interface seerd_if;
	logic scl;
	logic m_sda_o;
	logic m_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic sda;

	// open-drain line with pull-up: low whenever an enabled end drives low
	assign sda = ((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o)) ? 1'b0 : 1'b1;

	modport host (output scl, output m_sda_o, output m_sda_oe, input sda);
	modport dev (input scl, output d_sda_o, output d_sda_oe, input sda);
endinterface

/* File: core/seerd_slave.sv */
// memory end of the two-wire link: decode, pointer, read and write path
`timescale 1ns/100ps

// Functional notes
// - direction bit one selects a read
// - pointer holds last address plus one; a write wraps it within the 16-byte page
// - matching read byte: ack, send pointer word
// - master nack plus stop ends read
// - address write then restart loads pointer only
// - read control after restart returns new word
// - master ack requests the next word
// - pointer steps once per word transferred
// - data changes only while clock low
// - protect pin high blocks all writes
// - protect pin low allows writes
// - external address pins are ignored
// - ack only the fixed device type code
// - block bits are word address high bits
// - no ack during programming cycle
module seerd_slave #(
	parameter int WR_CYCLES = seerd_pkg::WR_CYCLES
) (
	input wire logic mclk_in, // system clock
	input wire logic rst_n_in, // async reset, active low
	seerd_if.dev bus, // two-wire link
	input wire logic wp_in, // write protect, high blocks writes
	input wire logic [2:0] unused_address_pins_in, // not connected inside
	output logic busy_out // programming cycle in progress
);
	typedef enum logic [2:0] {
		st_idle,
		st_ctrl,
		st_addr,
		st_wr,
		st_rd
	} seerd_st_e;

	logic [7:0] mem [0:seerd_pkg::MEM_DEPTH-1];

	logic [1:0] scl_sync_reg;
	logic [1:0] scl_sync_next;
	logic [1:0] sda_sync_reg;
	logic [1:0] sda_sync_next;
	// protect pin is a board level, so it is synchronised like the link
	logic [1:0] wp_sync_reg;
	logic [1:0] wp_sync_next;
	logic scl_prev_reg;
	logic sda_prev_reg;

	seerd_st_e st_reg;
	seerd_st_e st_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic [7:0] sh_reg;
	logic [7:0] sh_next;
	logic [seerd_pkg::MEM_AW-1:0] ptr_reg;
	logic [seerd_pkg::MEM_AW-1:0] ptr_next;
	logic [1:0] blk_reg;
	logic [1:0] blk_next;
	logic is_rd_reg;
	logic is_rd_next;
	logic mack_reg;
	logic mack_next;
	logic oe_reg;
	logic oe_next;
	logic wrote_reg;
	logic wrote_next;
	logic [seerd_pkg::BUSY_W-1:0] busy_reg;
	logic [seerd_pkg::BUSY_W-1:0] busy_next;
	logic mem_we;

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic [7:0] rd_word;
	logic [3:0] type_code;

	// only the second stage is read below; the first feeds it alone
	always_comb begin
		scl_sync_next = {scl_sync_reg[0], bus.scl};
		sda_sync_next = {sda_sync_reg[0], bus.sda};
		wp_sync_next = {wp_sync_reg[0], wp_in};
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			wp_sync_reg <= 2'h0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_sync_reg <= scl_sync_next;
			sda_sync_reg <= sda_sync_next;
			wp_sync_reg <= wp_sync_next;
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	assign scl_s = scl_sync_reg[1];
	assign sda_s = sda_sync_reg[1];
	assign scl_rise = scl_s & ~scl_prev_reg;
	assign scl_fall = ~scl_s & scl_prev_reg;
	// a data edge with the clock high is a frame mark, never data
	assign start_ev = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
	assign stop_ev = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

	assign rd_word = mem[ptr_reg];
	// the device type sits in the top nibble; the address pins never
	// enter this decode
	assign type_code = sh_reg[seerd_pkg::CTRL_TYPE_LSB +: 4];

	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		ptr_next = ptr_reg;
		blk_next = blk_reg;
		is_rd_next = is_rd_reg;
		mack_next = mack_reg;
		oe_next = oe_reg;
		wrote_next = wrote_reg;
		busy_next = busy_reg;
		mem_we = 1'b0;
		if (busy_reg != '0) begin
			busy_next = busy_reg - 1'b1;
		end
		if (stop_ev) begin
			// stop releases the line and launches programming if a data byte was written
			st_next = st_idle;
			oe_next = 1'b0;
			wrote_next = 1'b0;
			if (wrote_reg) begin
				busy_next = seerd_pkg::BUSY_W'(WR_CYCLES);
			end
		end else if (start_ev) begin
			// a restart mid-write lands here; acked bytes stay written and wrote_reg waits for the next stop
			st_next = st_ctrl;
			cnt_next = '0;
			oe_next = 1'b0;
		end else if (st_reg != st_idle) begin
			if (scl_rise) begin
				if (cnt_reg < seerd_pkg::BIT_ACK) begin
					// in read state this also moves the next bit up to bit 7
					sh_next = {sh_reg[6:0], sda_s};
				end else begin
					mack_next = ~sda_s;
				end
				cnt_next = cnt_reg + 1'b1;
			end else if (scl_fall) begin
				// every change of our drive happens on a falling clock
				if (cnt_reg == seerd_pkg::BIT_ACK) begin
					unique case (st_reg)
						st_ctrl: begin
							if (type_code == seerd_pkg::DEV_TYPE &&
								busy_reg == '0) begin
								oe_next = 1'b1;
								is_rd_next = sh_reg[seerd_pkg::CTRL_RW_POS];
								if (!sh_reg[seerd_pkg::CTRL_RW_POS]) begin
									blk_next = sh_reg[seerd_pkg::CTRL_BLK_LSB +: 2];
								end
							end else begin
								st_next = st_idle;
							end
						end
						st_addr: begin
							ptr_next = {blk_reg, sh_reg};
							oe_next = 1'b1;
						end
						st_wr: begin
							oe_next = 1'b1;
							if (!wp_sync_reg[1]) begin
								mem_we = 1'b1;
								wrote_next = 1'b1;
							end
							// a protected write is acked but leaves memory alone
							ptr_next = {ptr_reg[seerd_pkg::MEM_AW-1:seerd_pkg::PAGE_BITS],
								ptr_reg[seerd_pkg::PAGE_BITS-1:0] + 1'b1};
						end
						st_rd: begin
							oe_next = 1'b0;
						end
						default: begin
							oe_next = 1'b0;
						end
					endcase
				end else if (cnt_reg == seerd_pkg::BIT_END) begin
					cnt_next = '0;
					oe_next = 1'b0;
					unique case (st_reg)
						st_ctrl: begin
							if (is_rd_reg) begin
								st_next = st_rd;
								sh_next = rd_word;
								oe_next = ~rd_word[7];
								ptr_next = ptr_reg + 1'b1;
							end else begin
								st_next = st_addr;
							end
						end
						st_addr: begin
							st_next = st_wr;
						end
						st_rd: begin
							if (mack_reg) begin
								sh_next = rd_word;
								oe_next = ~rd_word[7];
								ptr_next = ptr_reg + 1'b1;
							end else begin
								// master withheld its ack: let go and wait for stop
								st_next = st_idle;
							end
						end
						default: begin
							st_next = st_reg;
						end
					endcase
				end else if (st_reg == st_rd) begin
					oe_next = ~sh_reg[7];
				end
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg <= st_idle;
			cnt_reg <= '0;
			sh_reg <= '0;
			ptr_reg <= '0;
			blk_reg <= '0;
			is_rd_reg <= 1'b0;
			mack_reg <= 1'b0;
			oe_reg <= 1'b0;
			wrote_reg <= 1'b0;
			busy_reg <= '0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			ptr_reg <= ptr_next;
			blk_reg <= blk_next;
			is_rd_reg <= is_rd_next;
			mack_reg <= mack_next;
			oe_reg <= oe_next;
			wrote_reg <= wrote_next;
			busy_reg <= busy_next;
		end
	end

	// array is nonvolatile storage, so it has no reset
	always_ff @(posedge mclk_in) begin
		if (mem_we) begin
			mem[ptr_reg] <= sh_reg;
		end
	end

	assign bus.d_sda_o = 1'b0;
	assign bus.d_sda_oe = oe_reg;
	assign busy_out = (busy_reg != '0);
endmodule

/* File: core/seerd_master.sv */
// bus master end: makes the serial clock and runs read and write frames
`timescale 1ns/100ps
module seerd_master (
	input wire logic mclk_in, // system clock
	input wire logic rst_n_in, // async reset, active low
	seerd_if.host bus, // two-wire link
	input wire logic cmd_valid_in, // command request
	output logic cmd_ready_out, // idle, command taken when valid
	input wire seerd_pkg::seerd_kind_e cmd_kind_in, // frame kind
	input wire logic [9:0] cmd_addr_in, // word address, block bits on top
	input wire logic [7:0] cmd_wdata_in, // byte for a write
	input wire logic [7:0] cmd_len_in, // bytes to read, zero reads one
	output logic [7:0] rd_data_out, // received byte
	output logic rd_valid_out, // one-cycle pulse per received byte
	output logic done_out, // one-cycle pulse at end of frame
	output logic nack_out // last frame lost an ack
);
	typedef enum logic {m_idle, m_run} seerd_mst_e;

	seerd_mst_e st_reg;
	seerd_mst_e st_next;
	logic [2:0] step_reg;
	logic [2:0] step_next;
	logic [1:0] q_reg;
	logic [1:0] q_next;
	logic [3:0] bit_reg;
	logic [3:0] bit_next;
	logic [seerd_pkg::DIV_W-1:0] div_reg;
	logic [seerd_pkg::DIV_W-1:0] div_next;
	seerd_pkg::seerd_kind_e kind_reg;
	seerd_pkg::seerd_kind_e kind_next;
	logic [9:0] addr_reg;
	logic [9:0] addr_next;
	logic [7:0] wdata_reg;
	logic [7:0] wdata_next;
	logic [7:0] rem_reg;
	logic [7:0] rem_next;
	logic [7:0] sh_reg;
	logic [7:0] sh_next;
	logic scl_reg;
	logic scl_next;
	logic oe_reg;
	logic oe_next;
	logic nack_reg;
	logic nack_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic rdv_reg;
	logic rdv_next;
	logic done_reg;
	logic done_next;
	logic [1:0] sda_sync_reg;
	logic sda_s;
	logic tick;
	logic is_tx;
	logic [2:0] adv;

	function automatic logic [7:0] byte_of(input logic [2:0] step,
		input logic [9:0] addr, input logic [7:0] wdata);
		logic [7:0] b;
		b = {seerd_pkg::DEV_TYPE, 1'b0, addr[9:8], 1'b0};
		if (step == seerd_pkg::STEP_CTRL_R) begin
			b[seerd_pkg::CTRL_RW_POS] = 1'b1;
		end else if (step == seerd_pkg::STEP_ADDR) begin
			b = addr[7:0];
		end else if (step == seerd_pkg::STEP_WDATA) begin
			b = wdata;
		end
		return b;
	endfunction

	assign sda_s = sda_sync_reg[1];
	assign tick = (div_reg == seerd_pkg::DIV_W'(seerd_pkg::SCL_QTR_CYCLES - 1));
	assign is_tx = (step_reg != seerd_pkg::STEP_RX);

	// after the address byte a write goes on to data, a read restarts
	always_comb begin
		adv = step_reg + 1'b1;
		if (step_reg == seerd_pkg::STEP_ADDR && kind_reg == seerd_pkg::seerd_write) begin
			adv = seerd_pkg::STEP_WDATA;
		end else if (step_reg == seerd_pkg::STEP_ADDR) begin
			adv = seerd_pkg::STEP_RESTART;
		end else if (step_reg == seerd_pkg::STEP_WDATA) begin
			adv = seerd_pkg::STEP_STOP;
		end
	end

	always_comb begin
		st_next = st_reg;
		step_next = step_reg;
		q_next = q_reg;
		bit_next = bit_reg;
		div_next = '0;
		kind_next = kind_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rem_next = rem_reg;
		sh_next = sh_reg;
		scl_next = scl_reg;
		oe_next = oe_reg;
		nack_next = nack_reg;
		rdata_next = rdata_reg;
		rdv_next = 1'b0;
		done_next = 1'b0;
		if (st_reg == m_idle) begin
			if (cmd_valid_in) begin
				st_next = m_run;
				kind_next = cmd_kind_in;
				addr_next = cmd_addr_in;
				wdata_next = cmd_wdata_in;
				rem_next = (cmd_len_in == '0) ? 8'h01 : cmd_len_in;
				nack_next = 1'b0;
				q_next = '0;
				bit_next = '0;
				step_next = (cmd_kind_in == seerd_pkg::seerd_cur_read) ?
					seerd_pkg::STEP_RESTART : seerd_pkg::STEP_START;
			end
		end else if (!tick) begin
			div_next = div_reg + 1'b1;
		end else begin
			q_next = q_reg + 1'b1;
			if (step_reg == seerd_pkg::STEP_START ||
				step_reg == seerd_pkg::STEP_RESTART) begin
				// data falls while the clock is high: start mark
				unique case (q_reg)
					2'h0: oe_next = 1'b0;
					2'h1: scl_next = 1'b1;
					2'h2: oe_next = 1'b1;
					2'h3: begin
						scl_next = 1'b0;
						step_next = adv;
						sh_next = byte_of(adv, addr_reg, wdata_reg);
					end
				endcase
			end else if (step_reg == seerd_pkg::STEP_STOP) begin
				unique case (q_reg)
					2'h0: oe_next = 1'b1;
					2'h1: scl_next = 1'b1;
					2'h2: oe_next = 1'b0;
					2'h3: begin
						st_next = m_idle;
						done_next = 1'b1;
					end
				endcase
			end else begin
				unique case (q_reg)
					2'h0: begin
						// data is only moved while the clock is low
						if (bit_reg < seerd_pkg::BIT_ACK) begin
							oe_next = is_tx & ~sh_reg[7];
						end else begin
							oe_next = ~is_tx & (rem_reg > 8'h01);
						end
					end
					2'h1: scl_next = 1'b1;
					2'h2: begin
						if (bit_reg < seerd_pkg::BIT_ACK) begin
							sh_next = {sh_reg[6:0], sda_s};
						end else if (is_tx && sda_s) begin
							nack_next = 1'b1;
						end
					end
					2'h3: begin
						scl_next = 1'b0;
						bit_next = bit_reg + 1'b1;
						if (bit_reg == seerd_pkg::BIT_ACK) begin
							bit_next = '0;
							if (!is_tx) begin
								rdata_next = sh_reg;
								rdv_next = 1'b1;
								rem_next = rem_reg - 1'b1;
								step_next = (rem_reg > 8'h01) ?
									seerd_pkg::STEP_RX : seerd_pkg::STEP_STOP;
							end else if (nack_reg) begin
								step_next = seerd_pkg::STEP_STOP;
							end else begin
								step_next = adv;
								sh_next = byte_of(adv, addr_reg, wdata_reg);
							end
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg <= m_idle;
			step_reg <= '0;
			q_reg <= '0;
			bit_reg <= '0;
			div_reg <= '0;
			kind_reg <= seerd_pkg::seerd_cur_read;
			addr_reg <= '0;
			wdata_reg <= '0;
			rem_reg <= '0;
			sh_reg <= '0;
			scl_reg <= 1'b1;
			oe_reg <= 1'b0;
			nack_reg <= 1'b0;
			rdata_reg <= '0;
			rdv_reg <= 1'b0;
			done_reg <= 1'b0;
			sda_sync_reg <= 2'h3;
		end else begin
			st_reg <= st_next;
			step_reg <= step_next;
			q_reg <= q_next;
			bit_reg <= bit_next;
			div_reg <= div_next;
			kind_reg <= kind_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rem_reg <= rem_next;
			sh_reg <= sh_next;
			scl_reg <= scl_next;
			oe_reg <= oe_next;
			nack_reg <= nack_next;
			rdata_reg <= rdata_next;
			rdv_reg <= rdv_next;
			done_reg <= done_next;
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
		end
	end

	assign bus.scl = scl_reg;
	assign bus.m_sda_o = 1'b0;
	assign bus.m_sda_oe = oe_reg;
	assign cmd_ready_out = (st_reg == m_idle);
	assign rd_data_out = rdata_reg;
	assign rd_valid_out = rdv_reg;
	assign done_out = done_reg;
	assign nack_out = nack_reg;
endmodule

/* File: dv/seerd_asserts.sv */
// concurrent checks on the two-wire link between both ends
`timescale 1ns/100ps
module seerd_asserts (
	input wire logic mclk_in, // system clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic scl, // serial clock
	input wire logic m_sda_o, // master data out
	input wire logic m_sda_oe, // master pulls sda low
	input wire logic d_sda_o, // device data out
	input wire logic d_sda_oe, // device pulls sda low
	input wire logic sda // resolved data line
);
	logic scl_reg;
	logic sda_reg;
	logic [3:0] bit_reg;
	logic [7:0] sh_reg;
	logic first_reg;
	logic rd_reg;
	logic nacked_reg;
	logic rise;
	logic start_ev;
	logic stop_ev;
	logic ack_slot;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	assign rise = scl & ~scl_reg;
	assign start_ev = scl & scl_reg & sda_reg & ~sda;
	assign stop_ev = scl & scl_reg & ~sda_reg & sda;
	assign ack_slot = rise & (bit_reg == 4'h8);

	// frame tracker: bit slot, first byte, read phase, master nack seen
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			first_reg <= 1'b0;
			rd_reg <= 1'b0;
			nacked_reg <= 1'b0;
		end else begin
			scl_reg <= scl;
			sda_reg <= sda;
			if (start_ev || stop_ev) begin
				bit_reg <= 4'h0;
				first_reg <= start_ev;
				rd_reg <= 1'b0;
				nacked_reg <= 1'b0;
			end else if (ack_slot) begin
				bit_reg <= 4'h0;
				first_reg <= 1'b0;
				if (first_reg) rd_reg <= sh_reg[0] & ~sda;
				nacked_reg <= rd_reg & ~first_reg & sda;
			end else if (rise) begin
				sh_reg <= {sh_reg[6:0], sda};
				bit_reg <= bit_reg + 4'h1;
			end
		end
	end

	sequence nack_s;
		rise && bit_reg == 4'h8 && rd_reg && !first_reg && sda;
	endsequence
	sequence stop_s;
		stop_ev;
	endsequence

	dev_change_low_a: assert property (
		$changed(d_sda_oe) |-> !scl && !scl_reg)
		else $error("device data moved while clock high");
	mst_cond_free_a: assert property (
		scl && scl_reg && $changed(m_sda_oe) |-> !d_sda_oe)
		else $error("start or stop while device drives");
	ctrl_ack_code_a: assert property (
		ack_slot && first_reg && !sda |-> sh_reg[7:4] == 4'ha)
		else $error("control byte acked with wrong type code");
	read_mst_quiet_a: assert property (
		rd_reg && !nacked_reg && rise && bit_reg < 4'h8 |-> !m_sda_oe)
		else $error("master drives during read data bits");
	write_dev_quiet_a: assert property (
		!rd_reg && rise && bit_reg < 4'h8 |-> !d_sda_oe)
		else $error("device drives during written bits");
	nack_release_a: assert property (
		nacked_reg |-> !d_sda_oe)
		else $error("device still drives after master nack");
	nack_stop_a: assert property (
		nack_s |-> ##[1:900] stop_s)
		else $error("no stop after master nack");
	write_ack_a: assert property (
		ack_slot && !first_reg && !rd_reg |-> !sda)
		else $error("written byte not acked");
	open_drain_a: assert property (
		!m_sda_o && !d_sda_o)
		else $error("data line driven high by an end");
endmodule

/* File: dv/testbench.sv */
// self-checking bench joining both ends of the two-wire link
`timescale 1ns/100ps
module testbench;
	logic mclk_in;
	logic rst_n_in;
	logic wp_in;
	logic [2:0] unused_address_pins_in;
	logic busy_out;
	logic cmd_valid_in;
	logic cmd_ready_out;
	seerd_pkg::seerd_kind_e cmd_kind_in;
	logic [9:0] cmd_addr_in;
	logic [7:0] cmd_wdata_in;
	logic [7:0] cmd_len_in;
	logic [7:0] rd_data_out;
	logic rd_valid_out;
	logic done_out;
	logic nack_out;
	int fails;
	int num_checks;
	int cycles;
	logic [7:0] exp_q[$];
	logic nack_q[$];
	logic [7:0] ctrl_q[$];
	logic [7:0] d0;
	logic [7:0] d1;
	logic [7:0] d2;
	logic scl_q;
	logic sda_q;
	logic [3:0] nbit;
	logic [7:0] sh;
	logic first;

	seerd_if link();
	// busy kept longer than one control byte so a read can hit it
	seerd_slave #(.WR_CYCLES(6000)) i_seerd_slave (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .bus(link), .wp_in(wp_in),
		.unused_address_pins_in(unused_address_pins_in), .busy_out(busy_out));
	seerd_master i_seerd_master (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.bus(link), .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
		.cmd_kind_in(cmd_kind_in), .cmd_addr_in(cmd_addr_in),
		.cmd_wdata_in(cmd_wdata_in), .cmd_len_in(cmd_len_in),
		.rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
		.done_out(done_out), .nack_out(nack_out));
	seerd_asserts i_seerd_asserts (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.scl(link.scl), .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
		.d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe), .sda(link.sda));

	initial begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic summarize();
		if (fails == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic run(input seerd_pkg::seerd_kind_e kind,
		input logic [9:0] addr, input logic [7:0] wdata,
		input logic [7:0] len, input logic nack);
		int n;
		n = 0;
		nack_q.push_back(nack);
		if (kind != seerd_pkg::seerd_cur_read)
			ctrl_q.push_back({4'ha, 1'b0, addr[9:8], 1'b0});
		if (kind != seerd_pkg::seerd_write)
			ctrl_q.push_back({4'ha, 1'b0, addr[9:8], 1'b1});
		while (cmd_ready_out !== 1'b1 && n < 100) begin
			@(negedge mclk_in);
			n++;
		end
		@(posedge mclk_in);
		cmd_valid_in <= 1'b1;
		cmd_kind_in <= kind;
		cmd_addr_in <= addr;
		cmd_wdata_in <= wdata;
		cmd_len_in <= len;
		unused_address_pins_in <= 3'($urandom);
		@(posedge mclk_in);
		cmd_valid_in <= 1'b0;
		n = 0;
		while (done_out !== 1'b1 && n < 40000) begin
			@(negedge mclk_in);
			n++;
		end
		if (kind == seerd_pkg::seerd_write)
			check({7'h0, busy_out}, {7'h0, ~wp_in});
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (busy_out !== 1'b0 && n < 10000) begin
			@(negedge mclk_in);
			n++;
		end
		check({7'h0, busy_out}, 8'h00);
	endtask

	// results and wire bytes are judged against notes left by the driver
	always @(negedge mclk_in) begin
		scl_q <= link.scl;
		sda_q <= link.sda;
		if (rst_n_in && rd_valid_out === 1'b1)
			check(rd_data_out, exp_q.size() ? exp_q.pop_front() : 8'hxx);
		if (rst_n_in && done_out === 1'b1)
			check({7'h0, nack_out}, {7'h0, nack_q.pop_front()});
		if (link.scl && scl_q && sda_q && !link.sda) begin
			nbit <= 4'h0;
			first <= 1'b1;
		end else if (link.scl && !scl_q && first) begin
			sh <= {sh[6:0], link.sda};
			nbit <= nbit + 4'h1;
			if (nbit == 4'h7) begin
				first <= 1'b0;
				check({sh[6:0], link.sda}, ctrl_q.pop_front());
			end
		end
	end

	// a hung frame would otherwise stall the run forever
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 95000) begin
			fails++;
			summarize();
		end
	end

	initial begin
		fails = 0;
		num_checks = 0;
		cycles = 0;
		first = 1'b0;
		nbit = 4'h0;
		sh = 8'h00;
		rst_n_in = 1'b0;
		wp_in = 1'b0;
		unused_address_pins_in = 3'h0;
		cmd_valid_in = 1'b0;
		cmd_kind_in = seerd_pkg::seerd_write;
		cmd_addr_in = 10'h000;
		cmd_wdata_in = 8'h00;
		cmd_len_in = 8'h00;
		void'($urandom(32'hff82b4ad));
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		d2 = ~d0;
		repeat (16) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		run(seerd_pkg::seerd_write, 10'h000, d0, 8'h00, 1'b0);
		wait_idle();
		run(seerd_pkg::seerd_write, 10'h3ff, d1, 8'h00, 1'b0);
		run(seerd_pkg::seerd_cur_read, 10'h000, 8'h00, 8'h00, 1'b1);
		wait_idle();
		@(posedge mclk_in);
		wp_in <= 1'b1;
		run(seerd_pkg::seerd_write, 10'h000, d2, 8'h00, 1'b0);
		@(posedge mclk_in);
		wp_in <= 1'b0;
		exp_q.push_back(d1);
		exp_q.push_back(d0);
		run(seerd_pkg::seerd_rand_read, 10'h3ff, 8'h00, 8'h02, 1'b0);
		check(8'(exp_q.size()), 8'h00);
		check(8'(ctrl_q.size()), 8'h00);
		summarize();
	end
endmodule
